// file: src/tpf_pkg.sv
package tpf_pkg;

  // Item, packet and frame geometry
  localparam int ITEM_W = 18;
  localparam int ITEMS = 32;
  localparam int WORDS = 20;
  localparam int WORDS_PER_FRAME = 4;
  localparam int FRAME_DATA_BYTES = 15;
  localparam int AUX_POS = 120;
  localparam int GROUP_ITEMS = 4;
  localparam int GROUP_BYTES = 9;
  localparam int HI_BYTE_INDEX = 8;
  localparam int HI_BITS_POS = 16;
  localparam int MID_BYTE_POS = 8;

  // Default encoding: identifier slots at the start of frames 0, 2 and 4
  localparam int DFLT_ID_SLOT_0 = 0;
  localparam int DFLT_ID_SLOT_1 = 30;
  localparam int DFLT_ID_SLOT_2 = 60;

  // Alternate encoding: first id, plain source id byte, second id, then data
  localparam int ALT_ID_A_SLOT = 0;
  localparam int ALT_SRC_SLOT = 1;
  localparam int ALT_ID_B_SLOT = 2;
  localparam int ALT_DATA_START = 3;

  // Encoding selection values
  localparam logic ENC_DEFAULT = 1'b0;
  localparam logic ENC_ALTERNATE = 1'b1;

  // Output selection values
  localparam logic [1:0] SEL_OFF = 2'h0;
  localparam logic [1:0] SEL_EXTERNAL = 2'h1;
  localparam logic [1:0] SEL_STREAM = 2'h2;
  localparam logic [1:0] SEL_MEMORY = 2'h3;

  // Register map
  localparam int APB_ADDR_W = 12;
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] ENABLE_OFFSET = 12'h004;
  localparam logic [11:0] STATUS_OFFSET = 12'h008;
  localparam logic [11:0] PKT_COUNT_OFFSET = 12'h00c;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
  localparam int STATUS_COUNT_POS = 0;
  localparam int STATUS_EMIT_POS = 8;

  typedef enum logic [2:0] {
    TPF_REG_NONE,
    TPF_REG_CTRL,
    TPF_REG_ENABLE,
    TPF_REG_STATUS,
    TPF_REG_PKT_COUNT
  } tpf_reg_type;

  typedef struct packed {
    logic [4:0] src;
    logic [ITEM_W-1:0] data;
  } tpf_item_type;

  typedef struct packed {
    logic [1:0] dest;
    logic last;
    logic [31:0] data;
  } tpf_word_type;

endpackage

// file: src/tpf_buffer.sv
`timescale 1ns/1ps
`default_nettype none

module tpf_buffer #(
  parameter int WIDTH = 35,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Filling side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Draining side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  import tpf_pkg::*;

  // Shift style: the head entry is always a register, so outputs need no mux
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [DEPTH-1:0] vld_reg;
  logic [DEPTH-1:0] vld_next;
  logic pop;
  logic push;
  logic placed;

  assign in_ready = ~vld_reg[DEPTH-1];
  assign out_data = mem_reg[0];
  assign out_valid = vld_reg[0];

  always_comb begin
    pop = out_ready & vld_reg[0];
    push = in_valid & ~vld_reg[DEPTH-1];
    placed = 1'b0;
    for (int i = 0; i < DEPTH - 1; i++) begin
      mem_next[i] = pop ? mem_reg[i+1] : mem_reg[i];
      vld_next[i] = pop ? vld_reg[i+1] : vld_reg[i];
    end
    mem_next[DEPTH-1] = mem_reg[DEPTH-1];
    vld_next[DEPTH-1] = pop ? 1'b0 : vld_reg[DEPTH-1];
    for (int i = 0; i < DEPTH; i++) begin
      if (push && !placed && !vld_next[i]) begin
        mem_next[i] = in_data;
        vld_next[i] = 1'b1;
        placed = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      vld_reg <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else if (ce) begin
      vld_reg <= vld_next;
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= mem_next[i];
      end
    end
  end

endmodule

`default_nettype wire

// file: src/tpf_formatter.sv
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Selection 1, 2 or 3 forwards items from every enabled processor; 0 drops them.
// - Same packet words for external port and memory master destinations.
// - Encoding parameter: 0 selects default, 1 selects alternate encoding.
// - Default identifier is debug chain number above five-bit processor index.
// - Alternate first identifier is source base, followed by the default identifier byte.
// - Alternate second identifier is source base plus one, then trace data.
// - A packet holds 32 items of 18 bits in 20 words, five frames.
// - Default encoding scatters item bits over fixed word and bit positions.
// - Default encoding ends with item 31 in the last word.
// - Alternate encoding places item 0 right after the second identifier.
// - Alternate encoding puts item 12 at the start of frame 2.
module tpf_formatter #(
  parameter logic ENCODING = 1'b0,
  parameter logic [2:0] DEBUG_CHAIN = 3'h1,
  parameter logic [7:0] TRACE_SOURCE_BASE = 8'h10,
  parameter int BUF_DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tpf_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Trace items
  input wire tpf_pkg::tpf_item_type item,
  input wire logic item_valid,
  output logic item_ready,
  // Packet words
  output tpf_pkg::tpf_word_type word,
  output logic word_valid,
  input wire logic word_ready
);
  import tpf_pkg::*;

  typedef enum {TPF_COLLECT, TPF_EMIT} tpf_state_type;

  localparam int PKT_BITS = ITEMS * ITEM_W;
  localparam int WORD_IDX_W = $clog2(WORDS);
  localparam int COUNT_W = $clog2(ITEMS + 1);

  // Byte k of the packed data stream: low, mid, low, mid ... then upper bits of the group
  function automatic logic [7:0] data_byte(input logic [PKT_BITS-1:0] v, input int k);
    int g;
    int r;
    int idx;
    logic [7:0] raw;
    g = k / GROUP_BYTES;
    r = k % GROUP_BYTES;
    raw = 8'h00;
    if (r == HI_BYTE_INDEX) begin
      for (int j = 0; j < GROUP_ITEMS; j++) begin
        idx = g * GROUP_ITEMS + j;
        raw[2*j +: 2] = v[idx*ITEM_W + HI_BITS_POS +: 2];
      end
    end else begin
      idx = g * GROUP_ITEMS + r / 2;
      raw = (r % 2 == 1) ? v[idx*ITEM_W + MID_BYTE_POS +: 8] : v[idx*ITEM_W +: 8];
    end
    return raw;
  endfunction

  // Returns {aux bit, byte} for byte b of frame f
  function automatic logic [8:0] frame_byte(input logic [PKT_BITS-1:0] v, input int f, input int b,
                                            input logic alt, input logic [7:0] src_id);
    int s;
    int k;
    logic is_id;
    logic [7:0] id;
    logic [7:0] raw;
    s = f * FRAME_DATA_BYTES + b;
    k = 0;
    is_id = 1'b0;
    id = 8'h00;
    raw = 8'h00;
    if (alt == ENC_DEFAULT) begin
      if (s == DFLT_ID_SLOT_0 || s == DFLT_ID_SLOT_1 || s == DFLT_ID_SLOT_2) begin
        is_id = 1'b1;
        id = src_id;
      end else begin
        k = s - 1;
        if (s > DFLT_ID_SLOT_1) begin
          k = k - 1;
        end
        if (s > DFLT_ID_SLOT_2) begin
          k = k - 1;
        end
        raw = data_byte(v, k);
      end
    end else begin
      if (s == ALT_ID_A_SLOT) begin
        is_id = 1'b1;
        id = TRACE_SOURCE_BASE;
      end else if (s == ALT_SRC_SLOT) begin
        raw = src_id;
      end else if (s == ALT_ID_B_SLOT) begin
        is_id = 1'b1;
        id = TRACE_SOURCE_BASE + 8'h01;
      end else begin
        raw = data_byte(v, s - ALT_DATA_START);
      end
    end
    if (is_id) begin
      return {1'b0, id[6:0], 1'b1};
    end else if (b % 2 == 0) begin
      return {raw[0], raw[7:1], 1'b0};
    end else begin
      return {1'b0, raw};
    end
  endfunction

  function automatic tpf_reg_type decode(input logic [APB_ADDR_W-1:0] addr);
    case (addr)
      CTRL_OFFSET: return TPF_REG_CTRL;
      ENABLE_OFFSET: return TPF_REG_ENABLE;
      STATUS_OFFSET: return TPF_REG_STATUS;
      PKT_COUNT_OFFSET: return TPF_REG_PKT_COUNT;
      default: return TPF_REG_NONE;
    endcase
  endfunction

  // Register file
  logic [1:0] sel_reg, sel_next;
  logic [31:0] enable_reg, enable_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [31:0] pkt_count_reg, pkt_count_next;

  // Packet assembly
  tpf_state_type state_reg, state_next;
  logic [COUNT_W-1:0] count_reg, count_next;
  logic [WORD_IDX_W-1:0] word_idx_reg, word_idx_next;
  logic [PKT_BITS-1:0] items_reg, items_next;
  logic [4:0] src_reg, src_next;
  logic [1:0] dest_reg, dest_next;
  logic item_ready_reg, item_ready_next;

  logic [7:0] src_id;
  logic [127:0] frame_bits;
  logic [8:0] fb;
  tpf_word_type fill_word;
  logic fill_valid;
  logic fill_ready;
  logic take_item;
  logic keep_item;

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign item_ready = item_ready_reg;
  assign src_id = {DEBUG_CHAIN, src_reg};

  always_comb begin
    sel_next = sel_reg;
    enable_next = enable_reg;
    prdata_next = prdata_reg;
    pslverr_next = pslverr_reg;
    // Zero wait: the answer is registered during the setup cycle
    pready_next = psel & ~penable;
    if (psel && !penable) begin
      pslverr_next = (decode(paddr) == TPF_REG_NONE);
      prdata_next = 32'h0000_0000;
      if (!pwrite) begin
        case (decode(paddr))
          TPF_REG_CTRL: prdata_next[1:0] = sel_reg;
          TPF_REG_ENABLE: prdata_next = enable_reg;
          TPF_REG_STATUS: begin
            prdata_next[STATUS_COUNT_POS +: COUNT_W] = count_reg;
            prdata_next[STATUS_EMIT_POS] = (state_reg == TPF_EMIT);
          end
          TPF_REG_PKT_COUNT: prdata_next = pkt_count_reg;
          default: prdata_next = 32'h0000_0000;
        endcase
      end
    end
    if (psel && penable && pready_reg && pwrite) begin
      case (decode(paddr))
        TPF_REG_CTRL: sel_next = pwdata[1:0];
        TPF_REG_ENABLE: enable_next = pwdata;
        default: sel_next = sel_reg;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sel_reg <= CTRL_RESET;
      enable_reg <= ENABLE_RESET;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (ce) begin
      sel_reg <= sel_next;
      enable_reg <= enable_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Whole current frame is built so its aux byte can see every even byte
  always_comb begin
    frame_bits = '0;
    fb = 9'h000;
    for (int b = 0; b < FRAME_DATA_BYTES; b++) begin
      fb = frame_byte(items_reg, int'(word_idx_reg) / WORDS_PER_FRAME, b, ENCODING, src_id);
      frame_bits[b*8 +: 8] = fb[7:0];
      if (b % 2 == 0) begin
        frame_bits[AUX_POS + b/2] = fb[8];
      end
    end
    fill_word.data = frame_bits[(int'(word_idx_reg) % WORDS_PER_FRAME)*32 +: 32];
    fill_word.last = (word_idx_reg == WORD_IDX_W'(WORDS - 1));
    fill_word.dest = dest_reg;
    fill_valid = (state_reg == TPF_EMIT);
  end

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    word_idx_next = word_idx_reg;
    items_next = items_reg;
    src_next = src_reg;
    dest_next = dest_reg;
    pkt_count_next = pkt_count_reg;
    take_item = item_valid & item_ready_reg;
    // Disabled processors and a closed output are drained, not stalled
    keep_item = (sel_reg != SEL_OFF) && enable_reg[item.src];
    case (state_reg)
      TPF_COLLECT: begin
        if (take_item && keep_item) begin
          items_next[int'(count_reg)*ITEM_W +: ITEM_W] = item.data;
          if (count_reg == '0) begin
            src_next = item.src;
            dest_next = sel_reg;
          end
          count_next = count_reg + COUNT_W'(1);
          if (count_reg == COUNT_W'(ITEMS - 1)) begin
            state_next = TPF_EMIT;
            word_idx_next = '0;
          end
        end
      end
      TPF_EMIT: begin
        if (fill_ready) begin
          word_idx_next = word_idx_reg + WORD_IDX_W'(1);
          if (word_idx_reg == WORD_IDX_W'(WORDS - 1)) begin
            state_next = TPF_COLLECT;
            count_next = '0;
            word_idx_next = '0;
            pkt_count_next = pkt_count_reg + 32'h0000_0001;
          end
        end
      end
      default: state_next = TPF_COLLECT;
    endcase
    // Items are refused while a packet drains, so packets never interleave
    item_ready_next = (state_next == TPF_COLLECT);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= TPF_COLLECT;
      count_reg <= '0;
      word_idx_reg <= '0;
      items_reg <= '0;
      src_reg <= 5'h00;
      dest_reg <= SEL_OFF;
      pkt_count_reg <= 32'h0000_0000;
      item_ready_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      count_reg <= count_next;
      word_idx_reg <= word_idx_next;
      items_reg <= items_next;
      src_reg <= src_next;
      dest_reg <= dest_next;
      pkt_count_reg <= pkt_count_next;
      item_ready_reg <= item_ready_next;
    end
  end

  // Receiver stalls back up into the emit counter through fill_ready
  tpf_buffer #(
    .WIDTH($bits(tpf_word_type)),
    .DEPTH(BUF_DEPTH)
  ) u_buffer (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .in_data(fill_word),
    .in_valid(fill_valid),
    .in_ready(fill_ready),
    .out_data(word),
    .out_valid(word_valid),
    .out_ready(word_ready)
  );

endmodule

`default_nettype wire

// file: tb/tpf_formatter_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module tpf_formatter_checker #(
  parameter logic ENCODING = 1'b0,
  parameter logic [7:0] TRACE_SOURCE_BASE = 8'h10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [tpf_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Items and words
  input wire logic item_ready,
  input wire tpf_pkg::tpf_word_type word,
  input wire logic word_valid,
  input wire logic word_ready
);
  import tpf_pkg::*;
  localparam logic [7:0] BASE_NEXT = TRACE_SOURCE_BASE + 8'h01;
  // Index of the word at the head, counted from the receiver's side
  logic [4:0] wcnt_reg;
  logic [4:0] wcnt_next;
  always_comb begin
    wcnt_next = wcnt_reg;
    if (ce && word_valid && word_ready) begin
      wcnt_next = word.last ? 5'h00 : wcnt_reg + 5'h01;
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wcnt_reg <= 5'h00;
    end else begin
      wcnt_reg <= wcnt_next;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_apb_answer; ce && psel && !penable |=> pready; endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("no answer after setup");
  property p_apb_err; ce && psel && !penable && paddr > 12'h00c |=> pslverr && prdata == 32'h0; endproperty
  a_apb_err: assert property (p_apb_err) else $error("unmapped access not refused");
  property p_hold; word_valid && !word_ready |=> word_valid && $stable(word); endproperty
  a_hold: assert property (p_hold) else $error("word changed while stalled");
  property p_last; word_valid |-> word.last == (wcnt_reg == 5'h13); endproperty
  a_last: assert property (p_last) else $error("last flag off word 19");
  property p_zero; word_valid && wcnt_reg[1:0] != 2'h0 |-> !word.data[0] && !word.data[16]; endproperty
  a_zero: assert property (p_zero) else $error("even data byte bit 0 set");
  property p_frame_id; word_valid && (wcnt_reg == 5'h08 || wcnt_reg == 5'h10) |-> word.data[0] == !ENCODING;
  endproperty
  a_frame_id: assert property (p_frame_id) else $error("frame id slot wrong");
  property p_id0; word_valid && wcnt_reg == 5'h00 |-> word.data[0] && word.data[16] == ENCODING &&
    (!ENCODING || {word.data[23:17], word.data[7:1]} == {BASE_NEXT[6:0], TRACE_SOURCE_BASE[6:0]}); endproperty
  a_id0: assert property (p_id0) else $error("identifiers of word 0 wrong");
  property p_fell_ready; $fell(item_ready) |=> word_valid; endproperty
  a_fell_ready: assert property (p_fell_ready) else $error("no word after full packet");
  property p_refuse; word_valid && wcnt_reg <= 5'h11 |-> !item_ready; endproperty
  a_refuse: assert property (p_refuse) else $error("items taken mid packet");
  c_last: cover property (word_valid && word_ready && word.last);
  c_stall: cover property (word_valid && !word_ready);
  c_err: cover property (pslverr);
endmodule
bind tpf_formatter tpf_formatter_checker #(.ENCODING(ENCODING), .TRACE_SOURCE_BASE(TRACE_SOURCE_BASE)) u_chk (
  .clk, .reset, .ce, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
  .item_ready, .word, .word_valid, .word_ready);
`default_nettype wire

// file: tb/tpf_word_sink.sv
`timescale 1ns/1ps
`default_nettype none
module tpf_word_sink (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Word side
  input wire logic stall_en,
  output logic word_ready
);
  logic [7:0] lfsr_reg;
  // Fixed sequence so both encodings stall alike
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lfsr_reg <= 8'h5a;
    end else begin
      lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
    end
  end
  assign word_ready = !stall_en || lfsr_reg[0] || lfsr_reg[2];
endmodule
`default_nettype wire

// file: tb/tpf_formatter_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tpf_formatter_tb_top;
  import tpf_pkg::*;
  localparam logic [2:0] CHAIN = 3'h1;
  localparam logic [7:0] BASE = 8'h10;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  tpf_item_type item = '0;
  logic item_valid = 1'b0;
  logic stall_en = 1'b0;
  logic [1:0] sels [5] = '{SEL_EXTERNAL, SEL_STREAM, SEL_STREAM, SEL_MEMORY, SEL_OFF};
  logic [32:0] apb_q[$];
  logic [32:0] apb_exp;
  int miscompares = 0;
  int total_checks = 0;
  always #10 clk = ~clk;

  task automatic check(input logic [34:0] seen, input logic [34:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    if (miscompares == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  for (genvar e = 0; e < 2; e++) begin : gen_enc
    tpf_word_type word;
    tpf_word_type exp_q[$];
    logic [31:0] prdata;
    logic pready, pslverr, item_ready, word_valid, word_ready;
    tpf_formatter #(.ENCODING(e == 1), .DEBUG_CHAIN(CHAIN), .TRACE_SOURCE_BASE(BASE)) u_dut (.clk, .reset,
      .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .item, .item_valid,
      .item_ready, .word, .word_valid, .word_ready);
    tpf_word_sink u_sink (.clk, .reset, .stall_en, .word_ready);
    always @(posedge clk) begin
      if (word_valid && word_ready) begin
        check(word, exp_q.size() > 0 ? exp_q.pop_front() : ~word);
      end
    end
  end

  // Both encodings share the bus, so the second copy must answer alike
  always @(posedge clk) begin
    if (psel && penable && gen_enc[0].pready) begin
      apb_exp = apb_q.pop_front();
      check({2'h0, gen_enc[0].pslverr, gen_enc[0].prdata}, {2'h0, apb_exp});
      check({gen_enc[1].pready, 1'b0, gen_enc[1].pslverr, gen_enc[1].prdata}, {2'h2, apb_exp});
    end
  end

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] ex);
    apb_q.push_back(ex);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (!gen_enc[0].pready);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [7:0] dbyte(input logic [17:0] it [32], input int k);
    int g;
    int r;
    g = k / 9;
    r = k % 9;
    if (r == 8) return {it[4*g+3][17:16], it[4*g+2][17:16], it[4*g+1][17:16], it[4*g][17:16]};
    return r[0] ? it[4*g+r/2][15:8] : it[4*g+r/2][7:0];
  endfunction

  // Frame bytes from the item stream, then words in ascending order
  task automatic push_pkt(input logic [17:0] it [32], input logic [4:0] src, input logic [1:0] dest);
    logic [7:0] v;
    logic [7:0] fb [16];
    logic isid;
    tpf_word_type w;
    int s;
    for (int e = 0; e < 2; e++) begin
      for (int f = 0; f < 5; f++) begin
        fb[15] = 8'h00;
        for (int p = 0; p < 15; p++) begin
          s = 15 * f + p;
          isid = e ? (s == 0 || s == 2) : (s == 0 || s == 30 || s == 60);
          if (e == 0) v = isid ? {CHAIN, src} : dbyte(it, s - 1 - (s > 30) - (s > 60));
          else v = s == 0 ? BASE : s == 1 ? {CHAIN, src} : s == 2 ? BASE + 8'h01 : dbyte(it, s - 3);
          fb[p] = v;
          if (!p[0]) begin
            fb[p] = isid ? {v[6:0], 1'b1} : {v[7:1], 1'b0};
            fb[15][p/2] = isid ? 1'b0 : v[0];
          end
        end
        for (int n = 0; n < 4; n++) begin
          w = {dest, f == 4 && n == 3, fb[4*n+3], fb[4*n+2], fb[4*n+1], fb[4*n]};
          if (e == 0) gen_enc[0].exp_q.push_back(w);
          else gen_enc[1].exp_q.push_back(w);
        end
      end
    end
  endtask

  // Item 5 comes from a disabled source and must be dropped
  task automatic send_pkt(input logic [1:0] sel, input logic [4:0] src, input logic [4:0] off);
    logic [17:0] it [32];
    for (int i = 0; i < 32; i++) it[i] = 18'($urandom);
    if (sel != SEL_OFF) push_pkt(it, src, sel);
    for (int i = 0; i < 33; i++) begin
      item <= i == 5 ? {off, 18'($urandom)} : {src, it[i - (i > 5)]};
      item_valid <= 1'b1;
      do begin
        @(posedge clk);
      end while (!gen_enc[0].item_ready);
    end
    // Idle edge so a back-to-back call never drives item_valid twice at once
    item_valid <= 1'b0;
    @(posedge clk);
  endtask

  initial begin
    #(20 * 20000);
    miscompares++;
    close_out;
  end

  initial begin
    logic [31:0] en;
    logic [4:0] src;
    void'($urandom(32'h9f68d84f));
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    apb(1'b0, CTRL_OFFSET, 32'h0, {1'b0, 30'h0, CTRL_RESET});
    apb(1'b0, ENABLE_OFFSET, 32'h0, {1'b0, ENABLE_RESET});
    apb(1'b1, STATUS_OFFSET, 32'hffff_ffff, 33'h0);
    apb(1'b0, STATUS_OFFSET, 32'h0, 33'h0);
    apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
    for (int k = 0; k < 5; k++) begin
      stall_en <= k[0];
      if (k != 2) begin
        src = 5'($urandom);
        en = $urandom | (32'h1 << src);
        en[src ^ 5'h01] = 1'b0;
        apb(1'b1, CTRL_OFFSET, {30'h0, sels[k]}, 33'h0);
        apb(1'b1, ENABLE_OFFSET, en, 33'h0);
        apb(1'b0, ENABLE_OFFSET, 32'h0, {1'b0, en});
      end
      send_pkt(sels[k], src, src ^ 5'h01);
    end
    // The wait ends once both expected queues are empty; a stuck packet leaves it to the watchdog, which fails the run
    while (gen_enc[0].exp_q.size() > 0 || gen_enc[1].exp_q.size() > 0) begin
      @(posedge clk);
    end
    apb(1'b0, STATUS_OFFSET, 32'h0, 33'h0);
    apb(1'b0, PKT_COUNT_OFFSET, 32'h0, 33'h4);
    close_out;
  end
endmodule
`default_nettype wire
